/* File: dv/ddc_decode_properties.sv */
// Concurrent checks on the ports of the command/address decode.
// Assumes one clock domain; die selection is checked only where chip ID
// is unused (single dies and x16 parts).
`timescale 1ns/1ps
module ddc_decode_props
   import ddc_pkg::*;
#(
   parameter int ORG = 4,
   parameter int STACK_H = 1,
   parameter logic [CID_W-1:0] DIE_ID = 3'h0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cke,
   input wire logic csN,
   input wire logic actN,
   input wire logic [1:0] bg,
   input wire logic [1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic parity,
   input wire logic parityEn,
   input wire logic cmdValid,
   input wire ddc_kind_t cmdKind,
   input wire logic [ADDR_W-1:0] rowAddr,
   input wire logic [COL_W-1:0] colAddr,
   input wire logic autoPre,
   input wire logic burstChop,
   input wire logic preAll,
   input wire logic [2:0] mrSel,
   input wire logic [ADDR_W-1:0] mrOpcode,
   input wire logic [1:0] bankGroup,
   input wire logic [1:0] bankAddr,
   input wire logic parityErr,
   input wire ddc_pwr_t pwrState,
   input wire logic [NBANK-1:0] bankOpen,
   input wire logic outDrvEn,
   input wire logic bufEnClk,
   input wire logic bufEnOdt,
   input wire logic bufEnCmd
);
   logic sel;
   assign sel = pwrState == PS_ACT && cke && !csN && !parityEn &&
      (STACK_H == 1 || ORG == ORG_X16);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////
   chk_deselect_ignored: assert property (
      csN |=> !cmdValid) else $error("command taken while deselected");
   chk_act_row: assert property (
      sel && !actN |=> cmdValid && cmdKind == CK_ACT && rowAddr ==
      (ORG == ORG_X4 ? $past(addr) : {1'b0, $past(addr[16:0])}) &&
      bankGroup == (ORG == ORG_X16 ? {1'b0, $past(bg[0])} : $past(bg)) &&
      bankAddr == $past(ba))
      else $error("activate fields wrong");
   chk_read_col: assert property (
      sel && actN && addr[16:14] == 3'b101 |=> cmdKind == CK_RD &&
      colAddr == $past(addr[9:0]) && autoPre == $past(addr[10]) &&
      burstChop == !$past(addr[12])) else $error("read fields wrong");
   chk_pre_all: assert property (
      sel && actN && addr[16:14] == 3'b010 |=> cmdKind == CK_PRE &&
      preAll == $past(addr[10])) else $error("precharge scope wrong");
   chk_mrs_opcode: assert property (
      sel && actN && addr[16:14] == 3'b000 |=> mrOpcode == $past(addr) &&
      mrSel == {$past(bg[0]), $past(ba)}) else $error("mode set wrong");
   chk_pd_entry: assert property (
      pwrState == PS_ACT && !cke && csN |=> pwrState ==
      ($past(bankOpen) != '0 ? PS_APD : PS_PPD))
      else $error("power-down kind wrong");
   chk_pd_exit: assert property (
      pwrState inside {PS_PPD, PS_APD} && cke |=> pwrState == PS_ACT)
      else $error("power-down exit missed");
   chk_pd_buffers: assert property (
      pwrState inside {PS_PPD, PS_APD} |-> bufEnClk && bufEnOdt &&
      !bufEnCmd && !outDrvEn) else $error("power-down buffers wrong");
   chk_sr_buffers: assert property (
      pwrState == PS_SR |-> !bufEnClk && !bufEnOdt && !bufEnCmd &&
      !outDrvEn) else $error("self refresh buffers wrong");
   chk_sr_wake: assert property (
      $rose(cke) && pwrState == PS_SR |-> ##[1:4] pwrState == PS_ACT)
      else $error("self refresh exit late");
   chk_asleep_mute: assert property (
      pwrState != PS_ACT |=> !cmdValid) else $error("command while asleep");
   chk_parity_drop: assert property (
      !csN && cke && parityEn && pwrState == PS_ACT &&
      ^{actN, (ORG == ORG_X16 ? bg[0] : ^bg), ba, addr[16:0], parity}
      |=> parityErr && !cmdValid)
      else $error("parity error not flagged");
endmodule

bind ddc_cmd_addr_decode ddc_decode_props #(.ORG(ORG), .STACK_H(STACK_H),
   .DIE_ID(DIE_ID)) props_u (.clk, .arst_n, .cke, .csN, .actN, .bg, .ba,
   .addr, .parity, .parityEn, .cmdValid, .cmdKind, .rowAddr, .colAddr,
   .autoPre, .burstChop, .preAll, .mrSel, .mrOpcode, .bankGroup, .bankAddr,
   .parityErr, .pwrState, .bankOpen, .outDrvEn, .bufEnClk, .bufEnOdt,
   .bufEnCmd);

/* File: dv/ddc_host_model.sv */
// Host controller model driving the command, address and control pins.
// Assumes the device samples every pin on the rising edge of clk.
`timescale 1ns/1ps
module ddc_host_model
   import ddc_pkg::*;
(
   input wire logic clk,
   output logic cke,
   output logic csN,
   output logic actN,
   output logic [CID_W-1:0] cid,
   output logic [1:0] bg,
   output logic [1:0] ba,
   output logic [ADDR_W-1:0] addr,
   output logic parity,
   output logic parityEn
);
   initial begin
      cke = 1'b1;
      csN = 1'b1;
      actN = 1'b1;
      cid = '0;
      bg = '0;
      ba = '0;
      addr = '0;
      parity = 1'b0;
      parityEn = 1'b0;
   end
   ////////////////////////////////////////
   // One selected cycle; bad flips the parity bit
   task automatic drive(input logic a, input logic [ADDR_W-1:0] ad,
      input logic [1:0] g, input logic [1:0] b, input logic ck,
      input logic bad);
      @(posedge clk);
      csN <= 1'b0;
      actN <= a;
      addr <= ad;
      bg <= g;
      ba <= b;
      cid <= {g[0], b};
      cke <= ck;
      parity <= ^{a, g, b, ad[16:0]} ^ bad;
   endtask
   // Deselected cycle: released pins except cid show the inverse of the last value
   task automatic idle(input logic ck);
      @(posedge clk);
      csN <= 1'b1;
      actN <= ~actN;
      addr <= ~addr;
      bg <= ~bg;
      ba <= ~ba;
      parity <= ~parity;
      cke <= ck;
   endtask
   task automatic setPar(input logic en);
      @(posedge clk);
      parityEn <= en;
   endtask
endmodule

/* File: dv/tb_ddc_cmd_addr_decode.sv */
// Self-checking bench for the command/address decode.
// Assumes the host model drives all pins on the rising clock edge.
`timescale 1ns/1ps
module tb_ddc_cmd_addr_decode
   import ddc_pkg::*;
;
   logic clk, arst_n, cke, csN, actN, parity, parityEn;
   logic [CID_W-1:0] cid, chipId;
   logic [1:0] bg, ba, bankGroup, bankAddr, bankGroupB;
   logic [ADDR_W-1:0] addr, rowAddr, mrOpcode, rowAddrB;
   logic [COL_W-1:0] colAddr;
   logic [2:0] mrSel;
   logic [NBANK-1:0] bankOpen, bankOpenB;
   logic cmdValid, autoPre, burstChop, preAll, parityErr;
   logic outDrvEn, intClkEn, bufEnClk, bufEnOdt, bufEnCmd;
   ddc_kind_t cmdKind;
   ddc_pwr_t pwrState;
   int failures, n_compared, n;
   ddc_kind_t kTab [8] = '{CK_MRS, CK_REF, CK_PRE, CK_NONE, CK_WR, CK_RD,
      CK_ZQ, CK_NONE};

   ddc_host_model host_u (.clk, .cke, .csN, .actN, .cid, .bg, .ba, .addr,
      .parity, .parityEn);
   ddc_cmd_addr_decode dut_u (.clk, .arst_n, .cke, .csN, .actN, .cid, .bg,
      .ba, .addr, .parity, .parityEn, .cmdValid, .cmdKind, .rowAddr,
      .colAddr, .autoPre, .burstChop, .preAll, .mrSel, .mrOpcode,
      .bankGroup, .bankAddr, .chipId, .parityErr, .pwrState, .bankOpen,
      .intClkEn, .outDrvEn, .bufEnClk, .bufEnOdt, .bufEnCmd);
   // x16 part with a stack setting: chip ID and BG1 must be ignored
   ddc_cmd_addr_decode #(.ORG(ORG_X16), .STACK_H(2), .DIE_ID(3'h1)) dut16_u (
      .clk, .arst_n, .cke, .csN, .actN, .cid, .bg, .ba, .addr, .parity,
      .parityEn, .cmdValid(), .cmdKind(), .rowAddr(rowAddrB), .colAddr(),
      .autoPre(), .burstChop(), .preAll(), .mrSel(), .mrOpcode(),
      .bankGroup(bankGroupB), .bankAddr(), .chipId(), .parityErr(),
      .pwrState(), .bankOpen(bankOpenB), .intClkEn(), .outDrvEn(),
      .bufEnClk(), .bufEnOdt(), .bufEnCmd());

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic cmpV(input logic [ADDR_W-1:0] g, input logic [ADDR_W-1:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic cmpB(input logic g, input logic e);
      cmpV(18'(g), 18'(e));
   endtask
   task automatic cmpK(input ddc_kind_t g, input ddc_kind_t e);
      cmpV(18'(g), 18'(e));
   endtask
   task automatic cmpP(input ddc_pwr_t g, input ddc_pwr_t e);
      cmpV(18'(g), 18'(e));
   endtask
   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic t_access();
      host_u.drive(1'b0, 18'h3a5c3, 2'h2, 2'h1, 1'b1, 1'b0);
      host_u.drive(1'b1, 18'h146b5, 2'h2, 2'h1, 1'b1, 1'b0);
      @(negedge clk);
      cmpK(cmdKind, CK_ACT);
      cmpV(rowAddr, 18'h3a5c3);
      cmpV(18'(bankOpen), 18'h00200);
      cmpV(18'({chipId, bankGroup, bankAddr}), 18'h00009);
      cmpV(rowAddrB, 18'h1a5c3);
      cmpV(18'({bankGroupB, bankOpenB}), 18'h00002);
      host_u.idle(1'b1);
      @(negedge clk);
      cmpK(cmdKind, CK_RD);
      cmpV(18'(colAddr), 18'h002b5);
      cmpB(autoPre & burstChop, 1'b1);
      cmpV(18'(bankOpen), 18'h0);
      host_u.drive(1'b1, 18'h11011, 2'h0, 2'h3, 1'b1, 1'b0);
      @(negedge clk);
      cmpB(cmdValid, 1'b0);
      cmpV(rowAddr, 18'h3a5c3);
      host_u.idle(1'b1);
      @(negedge clk);
      cmpK(cmdKind, CK_WR);
      cmpB(autoPre | burstChop, 1'b0);
      cmpV(18'(colAddr), 18'h00011);
   endtask
   task automatic t_codes();
      for (int i = 0; i < 8; i++) begin
         host_u.drive(1'b1, {1'b0, 3'(i), 14'h0400}, 2'h1, 2'h3, 1'b1, 1'b0);
         host_u.idle(1'b1);
         @(negedge clk);
         cmpK(cmdKind, kTab[i]);
         cmpB(cmdValid, kTab[i] != CK_NONE);
      end
      cmpV(mrOpcode, 18'h00400);
      cmpV(18'({mrSel, bankGroup, preAll}), 18'h0003b);
   endtask
   task automatic t_parity();
      host_u.setPar(1'b1);
      host_u.drive(1'b0, 18'h00123, 2'h1, 2'h1, 1'b1, 1'b1);
      host_u.drive(1'b0, 18'h00123, 2'h1, 2'h1, 1'b1, 1'b0);
      @(negedge clk);
      cmpB(parityErr & ~cmdValid, 1'b1);
      cmpV(18'(bankOpen), 18'h0);
      host_u.idle(1'b1);
      @(negedge clk);
      cmpB(cmdValid & ~parityErr, 1'b1);
      cmpV(18'(bankOpen), 18'h00020);
      host_u.setPar(1'b0);
   endtask
   task automatic t_power();
      host_u.drive(1'b0, 18'h0, 2'h3, 2'h0, 1'b1, 1'b0);
      host_u.drive(1'b0, 18'h0, 2'h1, 2'h2, 1'b1, 1'b0);
      host_u.drive(1'b1, 18'h08000, 2'h1, 2'h2, 1'b1, 1'b0);
      host_u.idle(1'b0);
      @(negedge clk);
      cmpV(18'({bankOpen, preAll}), 18'h02040);
      host_u.drive(1'b0, 18'h0, 2'h0, 2'h0, 1'b0, 1'b0);
      @(negedge clk);
      cmpP(pwrState, PS_APD);
      cmpV(18'({bufEnClk, bufEnOdt, bufEnCmd, outDrvEn, intClkEn}), 18'h18);
      host_u.idle(1'b1);
      host_u.idle(1'b1);
      @(negedge clk);
      cmpP(pwrState, PS_ACT);
      cmpV(18'(bankOpen), 18'h01020);
      cmpV(18'(bankOpenB), 18'h00030);
      host_u.drive(1'b1, 18'h08400, 2'h0, 2'h0, 1'b1, 1'b0);
      host_u.idle(1'b0);
      host_u.idle(1'b0);
      @(negedge clk);
      cmpP(pwrState, PS_PPD);
      repeat (5) host_u.idle(1'b1);
      host_u.drive(1'b1, 18'h04000, 2'h0, 2'h0, 1'b0, 1'b0);
      host_u.idle(1'b0);
      @(negedge clk);
      cmpP(pwrState, PS_SR);
      cmpB(bufEnClk | bufEnOdt | bufEnCmd | intClkEn, 1'b0);
      host_u.idle(1'b1);
      n = 0;
      while (pwrState !== PS_ACT && n < 8) begin
         @(negedge clk);
         n++;
      end
      if (n < 8) begin
         cmpB(n <= 4, 1'b1);
      end else begin
         failures++;
         tally_and_finish();
      end
   endtask
   ////////////////////////////////////////
   initial begin
      failures = 0;
      n_compared = 0;
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      cmpP(pwrState, PS_ACT);
      cmpK(cmdKind, CK_NONE);
      cmpB(bufEnCmd & bufEnClk & outDrvEn, 1'b1);
      t_access();
      t_codes();
      t_parity();
      t_power();
      tally_and_finish();
   end
endmodule

/* File: verilog/ddc_cmd_addr_decode.sv */
// Top of the command/address input decode: samples the pins, tracks open
// banks and the clock-enable power states, and drives the buffer enables.
// Assumes clk is the CK_t rising / CK_c falling crossing and that cke is
// a clean level, also used as the clock of the self-refresh wake path.
`timescale 1ns/1ps

// Behaviour
// (R1) Address is row on ACT, column on RD/WR
// (R2) Address is op-code during mode register set
// (R3) A17 used only for x4 organisation
// (R4) A10 on RD/WR requests auto precharge
// (R5) A10 on PRE selects all banks
// (R6) A12 low on RD/WR chops the burst
// (R7) ACT_n low: command pins become A16..A14
// (R8) Bank address picks bank or mode register
// (R9) Bank group picks group or mode register
// (R10) x16 uses only the lowest group bit
// (R11) Chip ID selects stacked die, not x16
// (R12) Dual-die parts use own CS and CKE
// (R13) All inputs sampled at clock crossing edge
// (R14) CKE high enables clocks, buffers, drivers
// (R15) CKE low enters power-down or self refresh
// (R16) Self refresh exit on CKE is asynchronous
// (R17) Controller holds CKE high during accesses
// (R18) Power-down keeps clock, ODT, reset, CKE buffers
// (R19) Self refresh keeps only CKE, reset buffers
// (R20) Commands ignored while chip select high
// (R21) Chip select is part of command code
// (R22) ACT_n high: RAS/CAS/WE are command pins
// (R23) Parity checked over command and address
// (R24) Command encoding follows the standard truth table
module ddc_cmd_addr_decode
   import ddc_pkg::*;
#(
   parameter int ORG = 4,
   parameter int STACK_H = 1,
   parameter logic [CID_W-1:0] DIE_ID = 3'h0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cke,
   input wire logic csN,
   input wire logic actN,
   input wire logic [CID_W-1:0] cid,
   input wire logic [1:0] bg,
   input wire logic [1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic parity,
   input wire logic parityEn,
   output logic cmdValid,
   output ddc_kind_t cmdKind,
   output logic [ADDR_W-1:0] rowAddr,
   output logic [COL_W-1:0] colAddr,
   output logic autoPre,
   output logic burstChop,
   output logic preAll,
   output logic [2:0] mrSel,
   output logic [ADDR_W-1:0] mrOpcode,
   output logic [1:0] bankGroup,
   output logic [1:0] bankAddr,
   output logic [CID_W-1:0] chipId,
   output logic parityErr,
   output ddc_pwr_t pwrState,
   output logic [NBANK-1:0] bankOpen,
   output logic intClkEn,
   output logic outDrvEn,
   output logic bufEnClk,
   output logic bufEnOdt,
   output logic bufEnCmd
);

   ////////////////////////////////////////////////////////////////////////
   // Pin decode

   ddc_dec_if dec();

   ddc_cmd_decode #(
      .ORG(ORG),
      .STACK_H(STACK_H),
      .DIE_ID(DIE_ID)
   ) uDecode (
      .csN(csN),
      .actN(actN),
      .cid(cid),
      .bg(bg),
      .ba(ba),
      .addr(addr),
      .parity(parity),
      .parityEn(parityEn),
      .dec(dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // Self-refresh wake path: toggle clocked by cke itself, then synchronised to clk

   logic wakeTgl_q;
   logic wakeTgl_d;

   always_comb begin
      wakeTgl_d = !wakeTgl_q;
   end

   always_ff @(posedge cke or negedge arst_n) begin
      if (!arst_n) begin
         wakeTgl_q <= 1'b0;
      end else begin
         wakeTgl_q <= wakeTgl_d; // R16
      end
   end

   logic wakeS1_q;
   logic wakeS2_q;
   logic wakeS3_q;
   logic wakeS1_d;
   logic wakeS2_d;
   logic wakeS3_d;
   logic wakeEvt;

   always_comb begin
      wakeS1_d = wakeTgl_q;
      wakeS2_d = wakeS1_q;
      wakeS3_d = wakeS2_q;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wakeS1_q <= 1'b0;
         wakeS2_q <= 1'b0;
         wakeS3_q <= 1'b0;
      end else begin
         wakeS1_q <= wakeS1_d;
         wakeS2_q <= wakeS2_d;
         wakeS3_q <= wakeS3_d;
      end
   end

   assign wakeEvt = wakeS2_q ^ wakeS3_q;

   ////////////////////////////////////////////////////////////////////////
   // Command acceptance

   ddc_pwr_t pwr_q;
   ddc_pwr_t pwr_d;
   logic [NBANK-1:0] bankOpen_q;
   logic [NBANK-1:0] bankOpen_d;
   logic inActive;
   logic sampled;
   logic accept;
   logic srEntry;
   logic [3:0] idx;

   always_comb begin
      inActive = (pwr_q == PS_ACT);
      // Command buffers are live only in the active state
      sampled = inActive && cke && dec.hit; // R13 R14 R17 R20
      accept = sampled && !dec.parErr; // R23
      srEntry = inActive && !cke && dec.hit && !dec.parErr &&
         (dec.kind == CK_REF) && (bankOpen_q == BANKS_RST); // R15
      idx = ddcBankIdx(dec.bg, dec.ba);
   end

   ////////////////////////////////////////////////////////////////////////
   // Power state

   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PS_ACT: begin
            if (!cke) begin
               if (srEntry) begin
                  pwr_d = PS_SR; // R15
               end else if (bankOpen_q != BANKS_RST) begin
                  pwr_d = PS_APD; // R15
               end else begin
                  pwr_d = PS_PPD; // R15
               end
            end
         end
         PS_PPD, PS_APD: begin
            if (cke) begin
               pwr_d = PS_ACT; // R14
            end
         end
         PS_SR: begin
            if (wakeEvt) begin
               pwr_d = PS_ACT; // R16
            end
         end
         default: pwr_d = PS_ACT;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_q <= PS_ACT;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Open-bank tracking

   always_comb begin
      bankOpen_d = bankOpen_q;
      if (accept) begin
         if (dec.kind == CK_ACT) begin
            bankOpen_d[idx] = 1'b1; // R1 R8 R9
         end else if (dec.kind == CK_RD || dec.kind == CK_WR) begin
            if (dec.autoPre) begin
               bankOpen_d[idx] = 1'b0; // R4
            end
         end else if (dec.kind == CK_PRE) begin
            if (dec.preAll) begin
               bankOpen_d = BANKS_RST; // R5
            end else begin
               bankOpen_d[idx] = 1'b0; // R5
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bankOpen_q <= BANKS_RST;
      end else begin
         bankOpen_q <= bankOpen_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered command outputs

   logic cmdValid_q;
   logic cmdValid_d;
   ddc_kind_t cmdKind_q;
   ddc_kind_t cmdKind_d;
   logic [ADDR_W-1:0] rowAddr_q;
   logic [ADDR_W-1:0] rowAddr_d;
   logic [COL_W-1:0] colAddr_q;
   logic [COL_W-1:0] colAddr_d;
   logic autoPre_q;
   logic autoPre_d;
   logic burstChop_q;
   logic burstChop_d;
   logic preAll_q;
   logic preAll_d;
   logic [2:0] mrSel_q;
   logic [2:0] mrSel_d;
   logic [ADDR_W-1:0] mrOpcode_q;
   logic [ADDR_W-1:0] mrOpcode_d;
   logic [1:0] bankGroup_q;
   logic [1:0] bankGroup_d;
   logic [1:0] bankAddr_q;
   logic [1:0] bankAddr_d;
   logic [CID_W-1:0] chipId_q;
   logic [CID_W-1:0] chipId_d;
   logic parityErr_q;
   logic parityErr_d;
   logic isRw;

   always_comb begin
      isRw = (dec.kind == CK_RD) || (dec.kind == CK_WR);
      cmdValid_d = accept && (dec.kind != CK_NONE); // R20 R21
      cmdKind_d = accept ? dec.kind : CK_NONE; // R22 R24
      parityErr_d = sampled && dec.parErr; // R23
      rowAddr_d = rowAddr_q;
      colAddr_d = colAddr_q;
      autoPre_d = autoPre_q;
      burstChop_d = burstChop_q;
      preAll_d = preAll_q;
      mrSel_d = mrSel_q;
      mrOpcode_d = mrOpcode_q;
      bankGroup_d = bankGroup_q;
      bankAddr_d = bankAddr_q;
      chipId_d = chipId_q;
      if (accept) begin
         chipId_d = dec.cid; // R11
         if (dec.kind == CK_ACT) begin
            rowAddr_d = dec.row; // R1 R7
         end
         if (isRw) begin
            colAddr_d = dec.col; // R1
            autoPre_d = dec.autoPre; // R4
            burstChop_d = dec.chop; // R6
         end
         if (dec.kind == CK_PRE) begin
            preAll_d = dec.preAll; // R5
         end
         if (dec.kind == CK_MRS) begin
            mrSel_d = dec.mrSel; // R8 R9
            mrOpcode_d = dec.mrOp; // R2
         end
         if (dec.kind == CK_ACT || isRw || dec.kind == CK_PRE) begin
            bankGroup_d = dec.bg; // R9 R10
            bankAddr_d = dec.ba; // R8
         end else if (dec.kind == CK_REF) begin
            bankGroup_d = dec.bg; // R9
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cmdValid_q <= 1'b0;
         cmdKind_q <= CK_NONE;
         rowAddr_q <= ADDR_RST;
         colAddr_q <= '0;
         autoPre_q <= 1'b0;
         burstChop_q <= 1'b0;
         preAll_q <= 1'b0;
         mrSel_q <= 3'h0;
         mrOpcode_q <= ADDR_RST;
         bankGroup_q <= 2'h0;
         bankAddr_q <= 2'h0;
         chipId_q <= 3'h0;
         parityErr_q <= 1'b0;
      end else begin
         cmdValid_q <= cmdValid_d;
         cmdKind_q <= cmdKind_d;
         rowAddr_q <= rowAddr_d;
         colAddr_q <= colAddr_d;
         autoPre_q <= autoPre_d;
         burstChop_q <= burstChop_d;
         preAll_q <= preAll_d;
         mrSel_q <= mrSel_d;
         mrOpcode_q <= mrOpcode_d;
         bankGroup_q <= bankGroup_d;
         bankAddr_q <= bankAddr_d;
         chipId_q <= chipId_d;
         parityErr_q <= parityErr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock, driver and input buffer enables

   logic intClkEn_q;
   logic intClkEn_d;
   logic outDrvEn_q;
   logic outDrvEn_d;
   logic bufEnClk_q;
   logic bufEnClk_d;
   logic bufEnOdt_q;
   logic bufEnOdt_d;
   logic bufEnCmd_q;
   logic bufEnCmd_d;

   // CKE and reset buffers are never switched off, so they have no enable
   always_comb begin
      intClkEn_d = (pwr_d == PS_ACT); // R14
      outDrvEn_d = (pwr_d == PS_ACT); // R14
      bufEnCmd_d = (pwr_d == PS_ACT); // R14 R18 R19
      bufEnClk_d = (pwr_d != PS_SR); // R18 R19
      bufEnOdt_d = (pwr_d != PS_SR); // R18 R19
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         intClkEn_q <= BUF_RST;
         outDrvEn_q <= BUF_RST;
         bufEnClk_q <= BUF_RST;
         bufEnOdt_q <= BUF_RST;
         bufEnCmd_q <= BUF_RST;
      end else begin
         intClkEn_q <= intClkEn_d;
         outDrvEn_q <= outDrvEn_d;
         bufEnClk_q <= bufEnClk_d;
         bufEnOdt_q <= bufEnOdt_d;
         bufEnCmd_q <= bufEnCmd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign cmdValid = cmdValid_q;
   assign cmdKind = cmdKind_q;
   assign rowAddr = rowAddr_q;
   assign colAddr = colAddr_q;
   assign autoPre = autoPre_q;
   assign burstChop = burstChop_q;
   assign preAll = preAll_q;
   assign mrSel = mrSel_q;
   assign mrOpcode = mrOpcode_q;
   assign bankGroup = bankGroup_q;
   assign bankAddr = bankAddr_q;
   assign chipId = chipId_q;
   assign parityErr = parityErr_q;
   assign pwrState = pwr_q;
   assign bankOpen = bankOpen_q;
   assign intClkEn = intClkEn_q;
   assign outDrvEn = outDrvEn_q;
   assign bufEnClk = bufEnClk_q;
   assign bufEnOdt = bufEnOdt_q;
   assign bufEnCmd = bufEnCmd_q;

endmodule

/* File: verilog/ddc_cmd_decode.sv */
// Combinational decode of the command, address and control pins.
// Assumes pins are stable around the clock edge that samples them.
`timescale 1ns/1ps
module ddc_cmd_decode
   import ddc_pkg::*;
#(
   parameter int ORG = 4,
   parameter int STACK_H = 1,
   parameter logic [CID_W-1:0] DIE_ID = 3'h0
) (
   input wire logic csN,
   input wire logic actN,
   input wire logic [CID_W-1:0] cid,
   input wire logic [1:0] bg,
   input wire logic [1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic parity,
   input wire logic parityEn,
   ddc_dec_if.src dec
);

   localparam logic [CID_W-1:0] CID_MASK = CID_W'(STACK_H - 1);
   localparam bit USE_CID = (ORG != ORG_X16) && (STACK_H > 1);

   logic [1:0] bgEff;
   logic [ADDR_W-1:0] addrEff;
   logic cidMatch;

   always_comb begin
      bgEff = (ORG == ORG_X16) ? {1'b0, bg[0]} : bg; // R10
      addrEff = addr;
      addrEff[TOP_BIT] = (ORG == ORG_X4) ? addr[TOP_BIT] : 1'b0; // R3
      // Dual-die parts select the die by their own CS/CKE/ODT
      cidMatch = USE_CID ? ((cid & CID_MASK) == (DIE_ID & CID_MASK))
                         : 1'b1; // R11 R12
      dec.hit = !csN && cidMatch; // R20 R21
      dec.cid = USE_CID ? (cid & CID_MASK) : 3'h0; // R11
      dec.bg = bgEff; // R9
      dec.ba = ba; // R8
      dec.row = addrEff; // R1 R7
      dec.col = addrEff[COL_W-1:0]; // R1
      dec.autoPre = addrEff[AP_BIT]; // R4
      dec.preAll = addrEff[AP_BIT]; // R5
      dec.chop = !addrEff[BC_BIT]; // R6
      dec.mrSel = {bgEff[0], ba}; // R8 R9
      dec.mrOp = addrEff; // R2
      dec.parErr = parityEn && !csN &&
         (^{actN, bgEff, ba, addrEff[MUX_HI:0], parity}); // R23
      if (!actN) begin
         dec.kind = CK_ACT; // R7
      end else begin
         unique case (addrEff[MUX_HI:MUX_LO]) // R22 R24
            3'b000: dec.kind = CK_MRS;
            3'b001: dec.kind = CK_REF;
            3'b010: dec.kind = CK_PRE;
            3'b100: dec.kind = CK_WR;
            3'b101: dec.kind = CK_RD;
            3'b110: dec.kind = CK_ZQ;
            3'b011, 3'b111: dec.kind = CK_NONE;
         endcase
      end
   end

endmodule

/* File: verilog/ddc_dec_if.sv */
// Decoded view of one sampled command cycle, from decoder to top.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface ddc_dec_if;
   import ddc_pkg::*;
   logic hit;
   ddc_kind_t kind;
   logic [ADDR_W-1:0] row;
   logic [COL_W-1:0] col;
   logic autoPre;
   logic chop;
   logic preAll;
   logic [2:0] mrSel;
   logic [ADDR_W-1:0] mrOp;
   logic [1:0] bg;
   logic [1:0] ba;
   logic [CID_W-1:0] cid;
   logic parErr;

   modport src(output hit, kind, row, col, autoPre, chop, preAll, mrSel,
      mrOp, bg, ba, cid, parErr);
   modport snk(input hit, kind, row, col, autoPre, chop, preAll, mrSel,
      mrOp, bg, ba, cid, parErr);
endinterface

/* File: verilog/ddc_pkg.sv */
// Constants, field positions and state types of the command/address decode.
// Assumes a single clock whose rising edge is the CK_t/CK_c crossing.
package ddc_pkg;

   localparam int ADDR_W = 18;
   localparam int COL_W = 10;
   localparam int CID_W = 3;
   localparam int NBANK = 16;
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   localparam int TOP_BIT = 17;
   localparam int MUX_LO = 14;
   localparam int MUX_HI = 16;
   localparam int ORG_X4 = 4;
   localparam int ORG_X16 = 16;

   localparam logic [NBANK-1:0] BANKS_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
   localparam logic BUF_RST = 1'b1;

   typedef enum logic [7:0] {
      CK_NONE = 8'h01,
      CK_ACT = 8'h02,
      CK_RD = 8'h04,
      CK_WR = 8'h08,
      CK_PRE = 8'h10,
      CK_REF = 8'h20,
      CK_MRS = 8'h40,
      CK_ZQ = 8'h80
   } ddc_kind_t;

   typedef enum logic [3:0] {
      PS_ACT = 4'h1,
      PS_PPD = 4'h2,
      PS_APD = 4'h4,
      PS_SR = 4'h8
   } ddc_pwr_t;

   function automatic logic [3:0] ddcBankIdx(input logic [1:0] bg,
                                             input logic [1:0] ba);
      return {bg, ba};
   endfunction

endpackage
